/* bench/cmo_prog_model.sv */
// Program memory model that answers table reads of the core memory block
`timescale 1ns/100ps
`default_nettype none
module cmo_prog_model
  import cmo_pkg::*;
(
  // Table read request
  input wire logic [PROG_ADDR_WIDTH-1:0] tblAddr,
  input wire logic tblRd,
  // Program word
  output logic [13:0] progData
);
  logic [13:0] word;
  assign word = {tblAddr[5:0], tblAddr[7:0]} ^ 14'h2c35;
  // Outside a read the bus shows the inverse, so a stale sample is caught
  assign progData = (tblRd === 1'b1) ? word : ~word;
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking testbench of the core memory block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cmo_pkg::*;
  logic mclk, reset_n, ackPulse, busy, tblRd, softReset, ovf, unf, sawSoft, sawBusy;
  cmo_mem_req_t memReq;
  cmo_flow_req_t flowReq;
  cmo_hw_evt_t hwEvt;
  logic [7:0] rdData, workOut, flagsOut, r;
  logic [14:0] pcOut, pcExp;
  logic [11:0] fetchAddr, tblAddr, lastTbl;
  logic [13:0] progData;
  logic [14:0] stk[$];
  int fails, checked, cyc, n;

  cmo_core_memory u_dut (.mclk(mclk), .reset_n(reset_n), .memReq(memReq), .rdData(rdData),
    .ackPulse(ackPulse), .busy(busy), .flowReq(flowReq), .pcOut(pcOut), .fetchAddr(fetchAddr),
    .tblAddr(tblAddr), .tblRd(tblRd), .progData(progData), .hwEvt(hwEvt),
    .stackOverflowFlag(ovf), .stackUnderflowFlag(unf), .softReset(softReset),
    .workOut(workOut), .flagsOut(flagsOut));
  cmo_prog_model u_prog (.tblAddr(tblAddr), .tblRd(tblRd), .progData(progData));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (tblRd === 1'b1) lastTbl <= tblAddr;
    if (softReset === 1'b1) sawSoft <= 1'b1;
    if (busy === 1'b1) sawBusy <= 1'b1;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One file register request, waits for its answer
  task automatic mem(input cmo_op_t op, input logic [6:0] a, input logic [7:0] d,
                     input logic dw);
    @(posedge mclk);
    #1 memReq = {op, dw, a, d};
    @(posedge mclk);
    #1 memReq.op = OP_NONE;
    n = 1;
    while (ackPulse !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1 n++;
    end
    r = rdData;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    mem(OP_WRITE, a, d, 1'b0);
  endtask

  task automatic rd(input logic [6:0] a);
    mem(OP_READ, a, 8'h00, 1'b0);
  endtask

  // Bits: step, jump, call, ret, intEntry, intReturn
  task automatic flow(input logic [5:0] k, input logic [14:0] t);
    @(posedge mclk);
    #1 flowReq = {k, t};
    @(posedge mclk);
    #1 flowReq = '0;
  endtask

  task automatic evt(input logic [4:0] e);
    @(posedge mclk);
    #1 hwEvt = e;
    @(posedge mclk);
    #1 hwEvt = '0;
  endtask

  task automatic arith(input cmo_op_t op, input logic [7:0] v, input logic [7:0] res,
                       input logic [7:0] fl);
    wr(7'h21, v);
    mem(op, 7'h21, 8'h00, 1'b0);
    chk("result", r, res);
    chk("aluFlags", flagsOut, fl);
  endtask

  initial begin
    reset_n = 1'b0;
    memReq = '0;
    flowReq = '0;
    hwEvt = '0;
    sawSoft = 1'b0;
    sawBusy = 1'b0;
    fails = 0;
    checked = 0;
    cyc = 0;
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("pcReset", pcOut, 16'h0000);
    chk("flagsReset", flagsOut, 16'h0018);
    chk("busyReset", busy, 16'h0000);
    wr(OFF_BANK, 8'h05);
    wr(OFF_FIRST_RAM, 8'ha5);
    wr(OFF_COMMON, 8'h77);
    wr(OFF_BANK, 8'h06);
    wr(OFF_FIRST_RAM, 8'h3c);
    wr(OFF_WORK, 8'h42);
    rd(OFF_BANK); chk("bank", r, 16'h0006);
    wr(OFF_BANK, 8'h05);
    rd(OFF_FIRST_RAM); chk("bank5", r, 16'h00a5);
    wr(OFF_BANK, 8'h1f);
    wr(7'h6f, 8'h5e);
    rd(7'h6f); chk("bank31", r, 16'h005e);
    wr(OFF_BANK, 8'h00);
    rd(OFF_COMMON); chk("common", r, 16'h0077);
    rd(OFF_WORK); chk("workMirror", r, 16'h0042);
    wr(7'h0c, 8'hff);
    rd(7'h0c); chk("periph", r, 16'h0000);
    wr(OFF_PTR0_HI, 8'h21);
    wr(OFF_PTR0_LO, 8'h90);
    rd(OFF_PORT0); chk("linear", r, 16'h00a5);
    wr(OFF_PTR1_HI, 8'h03);
    wr(OFF_PTR1_LO, 8'h20);
    rd(OFF_PORT1); chk("banked", r, 16'h003c);
    wr(OFF_PORT1, 8'h99);
    rd(OFF_PORT1); chk("portWrite", r, 16'h0099);
    rd(OFF_PTR1_LO); chk("ptrKept", r, 16'h0020);
    wr(OFF_PTR1_HI, 8'hb2);
    wr(OFF_PTR1_LO, 8'h34);
    mem(OP_READ, OFF_PORT1, 8'h00, 1'b1);
    chk("progCycles", 16'(n), 16'h0002);
    chk("progByte", r, 16'h0001);
    chk("progWork", workOut, 16'h0001);
    chk("progAddr", lastTbl, 16'h0234);
    chk("progBusy", sawBusy, 16'h0001);
    wr(OFF_PORT1, 8'hee);
    rd(OFF_PORT1); chk("progKept", r, 16'h0001);
    wr(OFF_FLAGS, 8'hff); chk("flagsWrite", flagsOut, 16'h001f);
    wr(OFF_FLAGS, 8'h02);
    mem(OP_CLEAR, OFF_FLAGS, 8'h00, 1'b0); chk("flagsClear", flagsOut, 16'h001e);
    wr(OFF_WORK, 8'h01);
    arith(OP_ADD, 8'h0f, 8'h10, 8'h1a);
    arith(OP_SUB, 8'h10, 8'h0f, 8'h19);
    arith(OP_SUB, 8'h00, 8'hff, 8'h18);
    arith(OP_SUB, 8'h01, 8'h00, 8'h1f);
    mem(OP_ADD, OFF_FLAGS, 8'h00, 1'b0); chk("flagsArith", flagsOut, 16'h001a);
    chk("flagsSum", r, 16'h0020);
    evt(5'b01000); chk("sleep", flagsOut[4:3], 16'h0002);
    evt(5'b10000); chk("wdt", flagsOut[4:3], 16'h0000);
    evt(5'b00100); chk("clrWdt", flagsOut[4:3], 16'h0003);
    wr(OFF_PC_UPPER, 8'h12);
    wr(OFF_PC_LOW, 8'h34); chk("pcLow", pcOut, 16'h1234);
    flow(6'b100000, 15'h0000); chk("step", pcOut, 16'h1235);
    flow(6'b010000, 15'h7ff0); chk("jump", pcOut, 16'h7ff0);
    chk("fetch", fetchAddr, 16'h0ff0);
    flow(6'b001000, 15'h0200); chk("call", pcOut, 16'h0200);
    flow(6'b000100, 15'h0000); chk("ret", pcOut, 16'h7ff1);
    wr(OFF_WORK, 8'h55);
    flow(6'b000010, 15'h0000); chk("intVec", pcOut, 16'h0004);
    wr(OFF_WORK, 8'haa);
    flow(6'b000001, 15'h0000); chk("intRet", pcOut, 16'h7ff1);
    chk("shadowWork", workOut, 16'h0055);
    hwEvt.stackRstEn = 1'b1;
    pcExp = 15'h7ff1;
    for (int i = 0; i < 17; i++) begin
      if (i < 16) stk.push_back(pcExp + 15'h0001);
      if (i == 16) chk("noOvf", ovf, 16'h0000);
      flow(6'b001000, 15'(i * 8));
      pcExp = 15'(i * 8);
    end
    @(posedge mclk);
    #1 chk("ovf", ovf, 16'h0001);
    chk("softReset", sawSoft, 16'h0001);
    while (stk.size() > 0) begin
      flow(6'b000100, 15'h0000);
      chk("pop", pcOut, stk.pop_back());
    end
    flow(6'b000100, 15'h0000);
    @(posedge mclk);
    #1 chk("unf", unf, 16'h0001);
    chk("unfPc", pcOut, 16'h0000);
    evt(5'b00001); chk("flagsClr", {ovf, unf}, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire

/* rtl/cmo_core_memory.sv */
// Core memory organization: data banks, pointers, flags, program counter and return stack
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Interrupt entry saves core registers to shadows; interrupt return restores all but intCtrl, time-out and power-down.
// - Return stack is its own memory: sixteen 15-bit return addresses.
// - Stack overflow/underflow set flags; with reset option, a software reset follows.
// - Two 16-bit pointers address all file registers and program memory.
// - Indirect reads of program memory take one extra cycle; indirect writes and arithmetic to it are answered in one.
// - General RAM is also reachable through a linear, non-banked pointer range.
// - Program counter is 15 bits, covering 32K words of 14 bits.
// - 4096 program words are implemented; higher addresses wrap around.
// - Reset starts at address 0000h; interrupts vector to 0004h.
// - Pointer high bit 7 set: indirect read returns low byte of program word.
// - Indirect writes aimed at program memory change nothing.
// - Data memory is 32 banks of 128 bytes.
// - Bank: 12 core, 20 peripheral, 80 RAM bytes, 16 shared common bytes.
// - Direct accesses use the bank last written to the bank select register.
// - Unimplemented data locations read as zero.
// - Core registers appear at offsets 00h to 0Bh of every bank.
// - Flag-updating instruction to flag register: computed flags replace written bits.
// - Time-out and power-down bits ignore software writes.
// - Clearing the flag register zeroes upper bits, sets zero, keeps the rest.
// - In subtraction carry and digit carry mean no borrow.
// - Subtraction adds the two's complement; carry one means no borrow.
// - Flag layout: time-out 4, power-down 3, zero 2, digit 1, carry 0.
// - Digit carry is the carry out of the low nibble.
module cmo_core_memory
  import cmo_pkg::*;
#(
  parameter int STACK_DEPTH = STACK_WORDS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // File register requests from the execution unit
  input wire cmo_mem_req_t memReq,
  output logic [7:0] rdData,
  output logic ackPulse,
  output logic busy,
  // Program flow
  input wire cmo_flow_req_t flowReq,
  output logic [PC_WIDTH-1:0] pcOut,
  output logic [PROG_ADDR_WIDTH-1:0] fetchAddr,
  // Program memory table read
  output logic [PROG_ADDR_WIDTH-1:0] tblAddr,
  output logic tblRd,
  input wire logic [13:0] progData,
  // Hardware events, reset status and working/flag register views
  input wire cmo_hw_evt_t hwEvt,
  output logic stackOverflowFlag,
  output logic stackUnderflowFlag,
  output logic softReset,
  output logic [7:0] workOut,
  output logic [7:0] flagsOut
);
  localparam int CW = $clog2(STACK_DEPTH + 1);
  localparam logic [CW-1:0] STK_FULL = CW'(STACK_DEPTH);

  function automatic cmo_target_t decodePtr(input logic [15:0] p);
    cmo_target_t t;
    logic [15:0] lin;
    t.kind = T_NONE;
    t.idx = 12'h000;
    lin = p - LINEAR_BASE;
    if (p[PROG_SEL_BIT]) begin
      t.kind = T_PROG;
      t.idx = p[11:0];
    end else if (p[15:12] == 4'h0) begin
      if (p[6:0] < OFF_FIRST_PERIPH) begin
        t.kind = T_CORE;
        t.idx = {5'h00, p[6:0]};
      end else if (p[6:0] >= OFF_COMMON) begin
        t.kind = T_COMMON;
        t.idx = {8'h00, p[3:0]};
      end else if (p[6:0] >= OFF_FIRST_RAM) begin
        t.kind = T_RAM;
        t.idx = 12'({7'h00, p[11:7]} * RAM_PER_BANK_W) + {5'h00, 7'(p[6:0] - OFF_FIRST_RAM)};
      end
    end else if (p >= LINEAR_BASE && p < LINEAR_END) begin
      t.kind = T_RAM;
      t.idx = lin[11:0];
    end
    return t;
  endfunction

  // Returns {carry, digitCarry, result}
  function automatic logic [9:0] addSub(input logic [7:0] a, input logic [7:0] b, input logic sub);
    logic [7:0] bb;
    logic [4:0] low;
    logic [8:0] full;
    bb = sub ? ~b : b;
    low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    full = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
    return {full[8], low[4], full[7:0]};
  endfunction

  logic [1:0] rstSync_reg;
  wire rstN = rstSync_reg[1];
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_reg <= 2'b00;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end

  cmo_core_t core_reg, core_next, shadow_reg, shadow_next;
  cmo_state_t state_reg, state_next;
  logic [PC_WIDTH-1:0] pc_reg, pc_next;
  logic [CW-1:0] stkCnt_reg, stkCnt_next;
  logic ovf_reg, ovf_next, unf_reg, unf_next, softRst_reg, softRst_next;
  logic [7:0] rdData_reg, rdData_next;
  logic ack_reg, ack_next, tblRd_reg, tblRd_next, pendWork_reg, pendWork_next;
  logic [11:0] tblAddr_reg, tblAddr_next;
  logic [7:0] ramMem [RAM_BYTES];
  logic [7:0] commonMem [COMMON_BYTES];
  logic [PC_WIDTH-1:0] stackMem [STACK_DEPTH];

  wire busyNow = (state_reg == S_PROG_WAIT);
  wire memGo = !busyNow && memReq.op != OP_NONE;
  wire flowGo = !busyNow;
  wire isPort = memReq.addr == OFF_PORT0 || memReq.addr == OFF_PORT1;
  wire [15:0] portPtr = (memReq.addr == OFF_PORT1) ? core_reg.ptr1 : core_reg.ptr0;
  wire [15:0] directPtr = {4'h0, core_reg.bankSel, memReq.addr};
  wire [15:0] effPtr = isPort ? portPtr : directPtr;
  wire cmo_target_t tgt = decodePtr(effPtr);
  // Port-to-port recursion lands on nothing
  wire coreHit = tgt.kind == T_CORE && tgt.idx[3:0] > 4'h1;
  wire [3:0] coreOff = tgt.idx[3:0];
  wire [7:0] flagsVal = {3'h0, core_reg.timeoutN, core_reg.powerDownN, core_reg.zero,
                         core_reg.digitCarry, core_reg.carry};

  logic [7:0] coreVal;
  always_comb begin
    case (coreOff)
      OFF_PC_LOW[3:0]: coreVal = pc_reg[7:0];
      OFF_FLAGS[3:0]: coreVal = flagsVal;
      OFF_PTR0_LO[3:0]: coreVal = core_reg.ptr0[7:0];
      OFF_PTR0_HI[3:0]: coreVal = core_reg.ptr0[15:8];
      OFF_PTR1_LO[3:0]: coreVal = core_reg.ptr1[7:0];
      OFF_PTR1_HI[3:0]: coreVal = core_reg.ptr1[15:8];
      OFF_BANK[3:0]: coreVal = {3'h0, core_reg.bankSel};
      OFF_WORK[3:0]: coreVal = core_reg.work;
      OFF_PC_UPPER[3:0]: coreVal = {1'b0, core_reg.pcUpper};
      OFF_INT_CTRL[3:0]: coreVal = core_reg.intCtrl;
      default: coreVal = 8'h00;
    endcase
  end

  wire [7:0] readVal = coreHit ? coreVal :
                       (tgt.kind == T_RAM) ? ramMem[tgt.idx] :
                       (tgt.kind == T_COMMON) ? commonMem[tgt.idx[3:0]] : 8'h00;
  wire isSub = memReq.op == OP_SUB;
  wire [9:0] aluOut = addSub(readVal, core_reg.work, isSub);
  wire [7:0] result = (memReq.op == OP_READ) ? readVal :
                      (memReq.op == OP_WRITE) ? memReq.data :
                      (memReq.op == OP_CLEAR) ? 8'h00 : aluOut[7:0];
  wire isArith = memReq.op == OP_ADD || isSub;
  wire updFlags = memGo && (isArith || memReq.op == OP_CLEAR);
  wire toWork = memReq.destWork && memReq.op != OP_WRITE;
  wire wrFile = memGo && !toWork && memReq.op != OP_READ;
  wire wrCore = wrFile && coreHit;
  wire progRead = memGo && memReq.op == OP_READ && tgt.kind == T_PROG;
  wire loadWork = memGo && toWork && !progRead;
  wire pcLowWrite = wrCore && coreOff == OFF_PC_LOW[3:0];

  always_comb begin
    core_next = core_reg;
    shadow_next = shadow_reg;
    if (wrCore) begin
      case (coreOff)
        OFF_FLAGS[3:0]: begin
          if (!updFlags) begin
            core_next.zero = result[FLAG_ZERO];
            core_next.digitCarry = result[FLAG_DIGIT];
            core_next.carry = result[FLAG_CARRY];
          end
        end
        OFF_PTR0_LO[3:0]: core_next.ptr0[7:0] = result;
        OFF_PTR0_HI[3:0]: core_next.ptr0[15:8] = result;
        OFF_PTR1_LO[3:0]: core_next.ptr1[7:0] = result;
        OFF_PTR1_HI[3:0]: core_next.ptr1[15:8] = result;
        OFF_BANK[3:0]: core_next.bankSel = result[4:0];
        OFF_WORK[3:0]: core_next.work = result;
        OFF_PC_UPPER[3:0]: core_next.pcUpper = result[6:0];
        OFF_INT_CTRL[3:0]: core_next.intCtrl = result;
        default: ;
      endcase
    end
    if (loadWork) begin
      core_next.work = result;
    end
    if (updFlags) begin
      core_next.zero = (result == 8'h00);
      if (isArith) begin
        core_next.digitCarry = aluOut[8];
        core_next.carry = aluOut[9];
      end
    end
    if (busyNow && pendWork_reg) begin
      core_next.work = progData[7:0];
    end
    if (hwEvt.clrWdt) begin
      core_next.timeoutN = 1'b1;
      core_next.powerDownN = 1'b1;
    end
    if (hwEvt.sleepExec) begin
      core_next.timeoutN = 1'b1;
      core_next.powerDownN = 1'b0;
    end
    if (hwEvt.wdtTimeout) begin
      core_next.timeoutN = 1'b0;
    end
    if (flowGo && flowReq.intEntry) begin
      shadow_next = core_reg;
    end else if (flowGo && flowReq.intReturn) begin
      core_next.work = shadow_reg.work;
      core_next.bankSel = shadow_reg.bankSel;
      core_next.pcUpper = shadow_reg.pcUpper;
      core_next.ptr0 = shadow_reg.ptr0;
      core_next.ptr1 = shadow_reg.ptr1;
      core_next.zero = shadow_reg.zero;
      core_next.digitCarry = shadow_reg.digitCarry;
      core_next.carry = shadow_reg.carry;
    end
  end

  logic doPush, doPop;
  logic [PC_WIDTH-1:0] pushVal;
  wire stkFull = stkCnt_reg == STK_FULL;
  wire stkEmpty = stkCnt_reg == '0;
  wire [CW-1:0] stkTop = CW'(stkCnt_reg - 1'b1);

  always_comb begin
    pc_next = pc_reg;
    pushVal = pc_reg;
    doPush = 1'b0;
    doPop = 1'b0;
    if (flowGo) begin
      if (flowReq.intEntry) begin
        doPush = 1'b1;
        pc_next = INT_VEC;
      end else if (flowReq.intReturn || flowReq.ret) begin
        doPop = 1'b1;
      end else if (flowReq.call) begin
        doPush = 1'b1;
        pushVal = PC_WIDTH'(pc_reg + 1'b1);
        pc_next = flowReq.target;
      end else if (flowReq.jump) begin
        pc_next = flowReq.target;
      end else if (pcLowWrite) begin
        pc_next = {core_reg.pcUpper, result};
      end else if (flowReq.step) begin
        pc_next = PC_WIDTH'(pc_reg + 1'b1);
      end
    end
    stkCnt_next = stkCnt_reg;
    if (doPush && !stkFull) begin
      stkCnt_next = CW'(stkCnt_reg + 1'b1);
    end
    if (doPop) begin
      pc_next = stkEmpty ? RESET_VEC : stackMem[stkTop[$clog2(STACK_DEPTH)-1:0]];
      stkCnt_next = stkEmpty ? stkCnt_reg : stkTop;
    end
  end

  wire ovfEvt = doPush && stkFull;
  wire unfEvt = doPop && stkEmpty;
  assign ovf_next = ovfEvt | (ovf_reg & ~hwEvt.stackFlagClr);
  assign unf_next = unfEvt | (unf_reg & ~hwEvt.stackFlagClr);
  assign softRst_next = (ovfEvt | unfEvt) & hwEvt.stackRstEn;

  assign state_next = progRead ? S_PROG_WAIT : S_IDLE;
  assign tblRd_next = progRead;
  assign tblAddr_next = progRead ? tgt.idx : tblAddr_reg;
  assign pendWork_next = progRead & memReq.destWork;
  assign ack_next = (memGo & ~progRead) | busyNow;
  assign rdData_next = busyNow ? progData[7:0] : (memGo ? result : rdData_reg);

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      core_reg <= CORE_RST;
      shadow_reg <= CORE_RST;
      state_reg <= S_IDLE;
      pc_reg <= RESET_VEC;
      stkCnt_reg <= '0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
      softRst_reg <= 1'b0;
      rdData_reg <= 8'h00;
      ack_reg <= 1'b0;
      tblRd_reg <= 1'b0;
      tblAddr_reg <= 12'h000;
      pendWork_reg <= 1'b0;
    end else begin
      core_reg <= core_next;
      shadow_reg <= shadow_next;
      state_reg <= state_next;
      pc_reg <= pc_next;
      stkCnt_reg <= stkCnt_next;
      ovf_reg <= ovf_next;
      unf_reg <= unf_next;
      softRst_reg <= softRst_next;
      rdData_reg <= rdData_next;
      ack_reg <= ack_next;
      tblRd_reg <= tblRd_next;
      tblAddr_reg <= tblAddr_next;
      pendWork_reg <= pendWork_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (wrFile && tgt.kind == T_RAM) begin
      ramMem[tgt.idx] <= result;
    end
    if (wrFile && tgt.kind == T_COMMON) begin
      commonMem[tgt.idx[3:0]] <= result;
    end
  end

  always_ff @(posedge mclk) begin
    if (doPush && !stkFull) begin
      stackMem[stkCnt_reg[$clog2(STACK_DEPTH)-1:0]] <= pushVal;
    end
  end

  assign rdData = rdData_reg;
  assign ackPulse = ack_reg;
  assign busy = busyNow;
  assign pcOut = pc_reg;
  assign fetchAddr = pc_reg[PROG_ADDR_WIDTH-1:0];
  assign tblAddr = tblAddr_reg;
  assign tblRd = tblRd_reg;
  assign stackOverflowFlag = ovf_reg;
  assign stackUnderflowFlag = unf_reg;
  assign softReset = softRst_reg;
  assign workOut = core_reg.work;
  assign flagsOut = flagsVal;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  sequence progReqS;
    progRead;
  endsequence
  sequence progDoneS;
    busy && tblRd && !ackPulse ##1 ackPulse && !busy;
  endsequence
  wire flagArith = memGo && isArith && wrCore && coreOff == OFF_FLAGS[3:0];
  wire flagClear = memGo && memReq.op == OP_CLEAR && wrCore && coreOff == OFF_FLAGS[3:0];
  wire flagWrite = memGo && memReq.op == OP_WRITE && wrCore && coreOff == OFF_FLAGS[3:0];
  wire noHwEvt = !hwEvt.clrWdt && !hwEvt.sleepExec && !hwEvt.wdtTimeout;

  progExtra_a: assert property (progReqS |=> progDoneS)
    else $error("program read did not take exactly one extra cycle");
  dataRead_a: assert property (memGo && !progRead |=> ackPulse && !busy)
    else $error("data access not answered in one cycle");
  intVector_a: assert property (flowGo && flowReq.intEntry && !stkFull
      |=> pcOut == INT_VEC && stkCnt_reg == $past(stkCnt_reg) + 1'b1)
    else $error("interrupt entry did not vector or push");
  shadowRet_a: assert property (flowGo && flowReq.intReturn && !flowReq.intEntry
      |=> workOut == $past(shadow_reg.work) && core_reg.ptr0 == $past(shadow_reg.ptr0))
    else $error("interrupt return did not restore shadows");
  stackOvf_a: assert property (ovfEvt |=> stackOverflowFlag && stkCnt_reg == STK_FULL)
    else $error("overflow flag not set on full push");
  stackUnf_a: assert property (unfEvt && hwEvt.stackRstEn
      |=> stackUnderflowFlag && softReset ##1 !softReset)
    else $error("underflow flag or single reset pulse missing");
  flagMask_a: assert property (flagArith && noHwEvt && !(flowGo && flowReq.intReturn)
      |=> flagsOut[FLAG_CARRY] == $past(aluOut[9])
      && flagsOut[FLAG_DIGIT] == $past(aluOut[8]))
    else $error("flag register write not masked by flag results");
  clearFlags_a: assert property (flagClear && noHwEvt && !(flowGo && flowReq.intReturn)
      |=> flagsOut[7:5] == 3'h0 && flagsOut[FLAG_ZERO]
      && $stable(flagsOut[FLAG_CARRY]) && $stable(flagsOut[FLAG_DIGIT]))
    else $error("clear of flag register changed kept bits");
  flagProtect_a: assert property (flagWrite && noHwEvt
      |=> $stable(flagsOut[FLAG_TIMEOUT]) && $stable(flagsOut[FLAG_POWER_DOWN]))
    else $error("software changed time-out or power-down");
  fetchWrap_a: assert property (progRead
      |=> tblRd && tblAddr == $past(effPtr[PROG_ADDR_WIDTH-1:0]))
    else $error("program address not wrapped");
endmodule

`default_nettype wire

/* rtl/cmo_pkg.sv */
// Constants, field layout and carrier types of the core memory block
package cmo_pkg;
  // Core register and region start offsets within every bank
  localparam logic [6:0] OFF_PORT0 = 7'h00;
  localparam logic [6:0] OFF_PORT1 = 7'h01;
  localparam logic [6:0] OFF_PC_LOW = 7'h02;
  localparam logic [6:0] OFF_FLAGS = 7'h03;
  localparam logic [6:0] OFF_PTR0_LO = 7'h04;
  localparam logic [6:0] OFF_PTR0_HI = 7'h05;
  localparam logic [6:0] OFF_PTR1_LO = 7'h06;
  localparam logic [6:0] OFF_PTR1_HI = 7'h07;
  localparam logic [6:0] OFF_BANK = 7'h08;
  localparam logic [6:0] OFF_WORK = 7'h09;
  localparam logic [6:0] OFF_PC_UPPER = 7'h0a;
  localparam logic [6:0] OFF_INT_CTRL = 7'h0b;
  localparam logic [6:0] OFF_FIRST_PERIPH = 7'h0c;
  localparam logic [6:0] OFF_FIRST_RAM = 7'h20;
  localparam logic [6:0] OFF_COMMON = 7'h70;
  // Flag register bit positions
  localparam int FLAG_TIMEOUT = 4;
  localparam int FLAG_POWER_DOWN = 3;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_DIGIT = 1;
  localparam int FLAG_CARRY = 0;
  // Memory sizes
  localparam int BANKS = 32;
  localparam int RAM_PER_BANK = 80;
  localparam int RAM_BYTES = BANKS * RAM_PER_BANK;
  localparam int COMMON_BYTES = 16;
  localparam int STACK_WORDS = 16;
  localparam int PC_WIDTH = 15;
  localparam int PROG_ADDR_WIDTH = 12;
  localparam logic [11:0] RAM_PER_BANK_W = 12'd80;
  // Vectors and pointer space
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] INT_VEC = 15'h0004;
  localparam int PROG_SEL_BIT = 15;
  localparam logic [15:0] LINEAR_BASE = 16'h2000;
  localparam logic [15:0] LINEAR_END = 16'(LINEAR_BASE + RAM_BYTES);

  typedef enum logic [2:0] {OP_NONE, OP_READ, OP_WRITE, OP_CLEAR, OP_ADD, OP_SUB} cmo_op_t;
  typedef enum logic [2:0] {T_NONE, T_CORE, T_RAM, T_COMMON, T_PROG} cmo_kind_t;
  typedef enum logic {S_IDLE, S_PROG_WAIT} cmo_state_t;

  typedef struct packed {
    cmo_op_t op;
    logic destWork;
    logic [6:0] addr;
    logic [7:0] data;
  } cmo_mem_req_t;

  typedef struct packed {
    logic step;
    logic jump;
    logic call;
    logic ret;
    logic intEntry;
    logic intReturn;
    logic [14:0] target;
  } cmo_flow_req_t;

  typedef struct packed {
    logic wdtTimeout;
    logic sleepExec;
    logic clrWdt;
    logic stackRstEn;
    logic stackFlagClr;
  } cmo_hw_evt_t;

  typedef struct packed {
    cmo_kind_t kind;
    logic [11:0] idx;
  } cmo_target_t;

  typedef struct packed {
    logic [7:0] work;
    logic [4:0] bankSel;
    logic [6:0] pcUpper;
    logic [7:0] intCtrl;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic timeoutN;
    logic powerDownN;
    logic zero;
    logic digitCarry;
    logic carry;
  } cmo_core_t;

  localparam cmo_core_t CORE_RST = '{timeoutN: 1'b1, powerDownN: 1'b1, default: '0};
endpackage
